/* File: hdl/pdec_pkg.sv */
package pdec_pkg;

  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned NUM_CH_DEFAULT  = 4;
  localparam int unsigned DUTY_W_DEFAULT  = 8;
  localparam int unsigned NUM_GEN_DEFAULT = 2;
  localparam int unsigned NUM_USR_DEFAULT = 2;
  // Time in ns the woken peripheral clock is kept after the last request
  localparam int unsigned WAKE_HOLD_NS     = 200;
  localparam int unsigned WAKE_HOLD_CYCLES = (WAKE_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned RESET_ENABLE_BIT = 0;
  localparam int unsigned RESET_RESPONSE   = 0;

  typedef struct packed {
    logic incr;
    logic decr;
  } pdec_step_type;

endpackage

/* File: hdl/pdec_route.sv */
`timescale 1ns/10ps
// Event routing: per user, OR of enabled generators, gated by user enable
module pdec_route #(
  parameter int unsigned NUM_GEN = pdec_pkg::NUM_GEN_DEFAULT,
  parameter int unsigned NUM_USR = pdec_pkg::NUM_USR_DEFAULT
) (
  input  wire logic               clk,           // Clock
  input  wire logic               reset_n,       // Async reset, active low
  input  wire logic [NUM_GEN-1:0] gen_event,     // Generator event pulses
  input  wire logic [NUM_GEN-1:0] gen_enable,    // Generator-side enables
  input  wire logic [NUM_USR-1:0] usr_enable,    // User-side enables
  input  wire logic [NUM_GEN-1:0] conn [NUM_USR], // Connection matrix per user
  output logic      [NUM_USR-1:0] usr_event      // Delivered events, registered
);
  initial
  begin
    if (NUM_GEN < 1 || NUM_USR < 1)
      $error("pdec_route: at least one generator and one user needed");
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      usr_event <= '0;
    else
      for (int u = 0; u < NUM_USR; u++)
        usr_event[u] <= usr_enable[u] & (|(gen_event & gen_enable & conn[u]));
  end

  property p_route_gate;
    @(posedge clk) disable iff (!reset_n)
      !usr_enable[0] |=> !usr_event[0];
  endproperty
  a_route_gate: assert property (p_route_gate) else $error("user event without user enable");

  property p_route_or;
    @(posedge clk) disable iff (!reset_n)
      (usr_enable[0] && |(gen_event & gen_enable & conn[0])) |=> usr_event[0];
  endproperty
  a_route_or: assert property (p_route_or) else $error("enabled generator event not delivered");
endmodule // pdec_route

/* File: hdl/pdec_top.sv */
`timescale 1ns/10ps
// What this block does
// - Step events ignored for a channel unless its enable bit is one.
// - One enable bit enables both increase and decrease events.
// - Each accepted step changes duty by one, once per period, saturating at zero and at the maximum.
// - Pending steps apply only when timebase reaches top.
// - Response bit 0: increase raises duty, decrease lowers it.
// - Response bit 1: event meanings swapped.
// - Simultaneous increase and decrease leave duty unchanged.
// - Number of event channels is a build parameter.
// - Channel-0 match event when timebase equals channel-0 duty.
// - Channel-0 match event has no enable, always generated.
// - Routing ORs all generators feeding one user.
// - Event acts only when enabled at generator and user.
// - Delivery needs no processor, works while both sides clocked.
// - Asynchronous event wakes only target clock, for needed time.
// - New duty values load into active duty only at top.
module pdec_top #(
  parameter int unsigned NUM_CH  = pdec_pkg::NUM_CH_DEFAULT,
  parameter int unsigned DUTY_W  = pdec_pkg::DUTY_W_DEFAULT,
  parameter int unsigned NUM_GEN = pdec_pkg::NUM_GEN_DEFAULT,
  parameter int unsigned NUM_USR = pdec_pkg::NUM_USR_DEFAULT
) (
  input  wire logic                    clk,                       // 20 MHz clock
  input  wire logic                    reset_n,                   // Async reset, active low
  input  wire logic [DUTY_W-1:0]       timebase_count,            // Shared timebase counter
  input  wire logic [DUTY_W-1:0]       timebase_top,              // Timebase top value
  input  wire logic [NUM_CH-1:0]       channel_event_enable,      // Per-channel event enable
  input  wire logic [NUM_CH-1:0]       channel_event_response,    // Per-channel direction swap
  input  wire logic [NUM_CH-1:0]       event_incr,                // Increase event pulses
  input  wire logic [NUM_CH-1:0]       event_decr,                // Decrease event pulses
  input  wire logic [NUM_CH-1:0]       duty_write,                // Software duty write strobes
  input  wire logic [DUTY_W-1:0]       duty_write_data,           // Duty value to write
  input  wire logic [NUM_GEN-1:0]      gen_event,                 // Other generators into routing
  input  wire logic [NUM_GEN-1:0]      gen_enable,                // Generator-side enables
  input  wire logic [NUM_USR-1:0]      usr_enable,                // User-side enables
  input  wire logic [NUM_GEN-1:0]      conn [NUM_USR],            // Routing matrix
  input  wire logic [NUM_USR-1:0]      usr_async,                 // User accepts asynchronous wake
  input  wire logic [NUM_USR-1:0]      usr_busy,                  // Woken function still working
  output logic      [DUTY_W-1:0]       duty_active [NUM_CH],      // Active duty values
  output logic                         first_channel_match_event, // Channel-0 match pulse
  output logic      [NUM_USR-1:0]      usr_event,                 // Delivered events
  output logic      [NUM_USR-1:0]      usr_clk_wake               // Per-user clock request
);
  localparam logic [DUTY_W-1:0] DUTY_MAX = '1;
  localparam int unsigned HOLD_W = $clog2(pdec_pkg::WAKE_HOLD_CYCLES + 1) + 1;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(pdec_pkg::WAKE_HOLD_CYCLES);

  initial
  begin
    if (NUM_CH < 1 || NUM_CH > 32 || DUTY_W < 2)
      $error("pdec_top: unsupported channel count or duty width");
  end

  // Step latch per channel, held until top
  pdec_pkg::pdec_step_type      pend_reg [NUM_CH];
  logic [DUTY_W-1:0]            shadow_reg [NUM_CH];
  logic [NUM_CH-1:0]            shadow_new_reg;
  logic [HOLD_W-1:0]            hold_reg [NUM_USR];
  logic [NUM_USR-1:0]           route_event;
  logic                         at_top;

  assign at_top = (timebase_count == timebase_top);

  function automatic logic [DUTY_W-1:0] step_duty(input logic [DUTY_W-1:0] d, input logic up, input logic dn);
    logic [DUTY_W-1:0] r;
    r = d;
    if (up && !dn && d != DUTY_MAX)
      r = d + DUTY_W'(1);
    else if (dn && !up && d != '0)
      r = d - DUTY_W'(1);
    return r;
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      for (int c = 0; c < NUM_CH; c++)
        pend_reg[c] <= '0;
    else
      for (int c = 0; c < NUM_CH; c++)
        if (at_top)
          pend_reg[c] <= '0;
        else if (channel_event_enable[c])
        begin
          if (event_incr[c])
            pend_reg[c].incr <= 1'b1 ^ channel_event_response[c] ? 1'b1 : pend_reg[c].incr;
          if (event_incr[c] && channel_event_response[c])
            pend_reg[c].decr <= 1'b1;
          if (event_decr[c] && !channel_event_response[c])
            pend_reg[c].decr <= 1'b1;
          if (event_decr[c] && channel_event_response[c])
            pend_reg[c].incr <= 1'b1;
        end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shadow_new_reg <= '0;
      for (int c = 0; c < NUM_CH; c++)
        shadow_reg[c] <= '0;
    end
    else
      for (int c = 0; c < NUM_CH; c++)
        if (duty_write[c])
        begin
          shadow_reg[c]     <= duty_write_data;
          shadow_new_reg[c] <= 1'b1;
        end
        else if (at_top)
          shadow_new_reg[c] <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      for (int c = 0; c < NUM_CH; c++)
        duty_active[c] <= '0;
    else if (at_top)
      for (int c = 0; c < NUM_CH; c++)
        duty_active[c] <= shadow_new_reg[c] ? shadow_reg[c]
                        : step_duty(duty_active[c], pend_reg[c].incr, pend_reg[c].decr);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      first_channel_match_event <= 1'b0;
    else
      first_channel_match_event <= (timebase_count == duty_active[0]);
  end

  pdec_route #(
    .NUM_GEN (NUM_GEN),
    .NUM_USR (NUM_USR)
  ) i_pdec_route (
    .clk        (clk),
    .reset_n    (reset_n),
    .gen_event  (gen_event),
    .gen_enable (gen_enable),
    .usr_enable (usr_enable),
    .conn       (conn),
    .usr_event  (route_event)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      usr_event <= '0;
    else
      usr_event <= route_event;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      usr_clk_wake <= '0;
      for (int u = 0; u < NUM_USR; u++)
        hold_reg[u] <= '0;
    end
    else
      for (int u = 0; u < NUM_USR; u++)
      begin
        if (route_event[u] && usr_async[u])
          hold_reg[u] <= HOLD_LOAD;
        else if (hold_reg[u] != '0 && !usr_busy[u])
          hold_reg[u] <= hold_reg[u] - HOLD_W'(1);
        usr_clk_wake[u] <= (route_event[u] && usr_async[u]) || usr_busy[u] || (hold_reg[u] > HOLD_W'(1));
      end
  end

  property p_no_change_off_top;
    @(posedge clk) disable iff (!reset_n)
      !at_top |=> $stable(duty_active[0]);
  endproperty
  a_no_change_off_top: assert property (p_no_change_off_top) else $error("duty changed off top");

  property p_disabled_ignored;
    @(posedge clk) disable iff (!reset_n)
      (!channel_event_enable[0] && !at_top) |=> (pend_reg[0] == $past(pend_reg[0]));
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled channel took event");

  property p_step_up;
    @(posedge clk) disable iff (!reset_n)
      (at_top && !shadow_new_reg[0] && pend_reg[0].incr && !pend_reg[0].decr && duty_active[0] != DUTY_MAX)
      |=> duty_active[0] == $past(duty_active[0]) + DUTY_W'(1);
  endproperty
  a_step_up: assert property (p_step_up) else $error("increase step not exactly one");

  property p_cancel;
    @(posedge clk) disable iff (!reset_n)
      (at_top && !shadow_new_reg[0] && pend_reg[0].incr && pend_reg[0].decr) |=> $stable(duty_active[0]);
  endproperty
  a_cancel: assert property (p_cancel) else $error("both events changed duty");

  property p_saturate;
    @(posedge clk) disable iff (!reset_n)
      (at_top && !shadow_new_reg[0] && duty_active[0] == '0) |=> duty_active[0] != DUTY_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("duty wrapped below zero");

  property p_swap;
    @(posedge clk) disable iff (!reset_n)
      (channel_event_enable[0] && channel_event_response[0] && event_incr[0] && !at_top) |=> pend_reg[0].decr;
  endproperty
  a_swap: assert property (p_swap) else $error("swapped increase not recorded as decrease");

  property p_match;
    @(posedge clk) disable iff (!reset_n)
      (timebase_count == duty_active[0]) |=> first_channel_match_event;
  endproperty
  a_match: assert property (p_match) else $error("channel-0 match event missing");

  property p_shadow_load;
    @(posedge clk) disable iff (!reset_n)
      (at_top && shadow_new_reg[0]) |=> duty_active[0] == $past(shadow_reg[0]);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded at top");

  c_step:  cover property (@(posedge clk) disable iff (!reset_n) at_top && pend_reg[0].incr);
  c_match: cover property (@(posedge clk) disable iff (!reset_n) first_channel_match_event);
  c_wake:  cover property (@(posedge clk) disable iff (!reset_n) usr_clk_wake[0]);
endmodule // pdec_top

/* File: verif/pdec_event_net.sv */
`timescale 1ns/10ps
// Event network model: shared timebase plus step and generator pulses
module pdec_event_net #(
  parameter logic [7:0] TOP = 8'h07
) (
  input  wire logic       clk,     // Clock
  input  wire logic       reset_n, // Async reset, active low
  output logic      [7:0] count,   // Shared timebase counter
  output logic      [7:0] top,     // Timebase top value
  output logic      [3:0] incr,    // Increase event pulses
  output logic      [3:0] decr,    // Decrease event pulses
  output logic      [1:0] gen      // Other generator pulses
);
  assign top = TOP;
  initial {incr, decr, gen} = '0;
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      count <= 8'h00;
    else
      count <= #1 (count == top) ? 8'h00 : count + 8'h01;
  // Pulses held n cycles, launched well clear of the top cycle
  task automatic step(input logic [3:0] i, input logic [3:0] d, input int n);
    @(posedge clk iff count == 8'h01);
    #1 incr = i;
    decr = d;
    repeat (n) @(posedge clk);
    #1 incr = 4'h0;
    decr = 4'h0;
  endtask
  task automatic fire(input logic [1:0] g);
    @(posedge clk);
    #1 gen = g;
    @(posedge clk);
    #1 gen = 2'b00;
  endtask
endmodule // pdec_event_net

/* File: verif/pdec_top_bench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module pdec_top_bench;
  logic       clk, reset_n, match, e, r, i, d;
  logic [7:0] count, top, wdata, p, seen;
  logic [3:0] en, rsp, incr, decr, wr;
  logic [1:0] gen, ge, ue, ua, ub, uev, wake, g;
  logic [1:0] conn [2];
  logic [7:0] duty [4];
  logic [7:0] exp_d [4];
  logic [3:0] cases [6] = '{4'b0010, 4'b1010, 4'b1001, 4'b1110, 4'b1101, 4'b1011};
  int         fails, n_compared;

  pdec_event_net i_pdec_event_net (.clk(clk), .reset_n(reset_n), .count(count), .top(top),
    .incr(incr), .decr(decr), .gen(gen));
  pdec_top i_pdec_top (.clk(clk), .reset_n(reset_n), .timebase_count(count), .timebase_top(top),
    .channel_event_enable(en), .channel_event_response(rsp), .event_incr(incr), .event_decr(decr),
    .duty_write(wr), .duty_write_data(wdata), .gen_event(gen), .gen_enable(ge), .usr_enable(ue),
    .conn(conn), .usr_async(ua), .usr_busy(ub), .duty_active(duty),
    .first_channel_match_event(match), .usr_event(uev), .usr_clk_wake(wake));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] sat(input logic [7:0] v, input logic up);
    if (up)
      return (v == 8'hff) ? v : v + 8'h01;
    return (v == 8'h00) ? v : v - 8'h01;
  endfunction

  task automatic summarize;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_top;
    @(posedge clk iff count == top);
    @(posedge clk iff count == 8'h01);
    #2;
  endtask

  task automatic check_duty;
    for (int c = 0; c < 4; c++)
      `CHK(duty[c], exp_d[c])
  endtask

  task automatic write_all(input logic [7:0] v);
    @(posedge clk iff count == 8'h01);
    #1 wr = 4'hf;
    wdata = v;
    @(posedge clk);
    #1 wr = 4'h0;
    #1 `CHK(duty[0], exp_d[0])
    wait_top();
    exp_d = '{default: v};
    check_duty();
  endtask

  initial
  begin
    #2000000;
    fails++;
    summarize();
  end

  initial
  begin
    reset_n = 1'b0;
    {en, rsp, wr, ge, ue, ua, ub} = '0;
    wdata = 8'h00;
    conn[0] = 2'b11;
    conn[1] = 2'b01;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    #1 exp_d = '{default: 8'h00};
    check_duty();
    write_all(8'h80);
    // Enable and response combinations except disabled with swap, pulses doubled in one period
    foreach (cases[k])
      for (int c = 0; c < 4; c++)
      begin
        {e, r, i, d} = cases[k];
        en = 4'(e) << c;
        rsp = 4'(r) << c;
        i_pdec_event_net.step(4'(i) << c, 4'(d) << c, 2);
        if (e && i != d)
          exp_d[c] = sat(exp_d[c], i ^ r);
        wait_top();
        check_duty();
      end
    en = 4'hf;
    rsp = 4'h0;
    write_all(8'hff);
    i_pdec_event_net.step(4'hf, 4'h0, 1);
    wait_top();
    check_duty();
    write_all(8'h00);
    i_pdec_event_net.step(4'h0, 4'hf, 1);
    wait_top();
    check_duty();
    en = 4'h0;
    write_all(8'h05);
    repeat (16)
    begin
      @(posedge clk);
      p = count;
      #2 `CHK(match, p == 8'h05)
    end
    for (int k = 0; k < 48; k++)
    begin
      ge = k[1:0];
      ue = k[3:2];
      g = 2'(k / 16 + 1);
      seen = 8'h00;
      i_pdec_event_net.fire(g);
      repeat (5)
      begin
        @(posedge clk);
        #2 seen = seen + {4'(uev[1]), 4'(uev[0])};
      end
      `CHK(seen, {3'h0, ue[1] & |(conn[1] & ge & g), 3'h0, ue[0] & |(conn[0] & ge & g)})
    end
    // Wake comes from the event alone, then busy stretches it
    {ua, ub, ge, ue} = 8'b01001111;
    i_pdec_event_net.fire(2'b01);
    repeat (3) @(posedge clk);
    #2 `CHK(wake, 2'b01)
    @(posedge clk);
    #1 ub = 2'b01;
    repeat (8) @(posedge clk);
    #2 `CHK(wake, 2'b01)
    @(posedge clk);
    #1 ub = 2'b00;
    repeat (pdec_pkg::WAKE_HOLD_CYCLES + 3) @(posedge clk);
    #2 `CHK(wake, 2'b00)
    // Mid-run reset clears active duty and all outputs
    @(posedge clk);
    #1 reset_n = 1'b0;
    #1 exp_d = '{default: 8'h00};
    check_duty();
    `CHK({match, uev, wake}, 5'h00)
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #2 check_duty();
    summarize();
  end
endmodule // pdec_top_bench
